// file: logic/fdrs_pkg.sv
// Purpose: Shared constants and types of the floppy rate/status registers
// Assumes: 10-bit I/O addressing, 8-bit data
// Notes:   Address, field positions, rate-side reset values and step limit live here

package fdrs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses and widths
  localparam int unsigned ADDR_W = 10;          // I/O address width
  localparam int unsigned DATA_W = 8;           // I/O data width
  // Shared address: reads see the input status, writes the rate config
  localparam logic [9:0] ADDR_RATE_STATUS = 10'h3f7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned DIR_CHANGED_BIT = 7;  // disk_changed in input reg
  localparam int unsigned M30_XFER_BIT    = 3;  // transfer_request_enable
  localparam int unsigned M30_PRECOMP_BIT = 2;  // precomp_disable
  localparam int unsigned DOR_XFER_BIT    = 3;  // position in output reg
  localparam int unsigned CFG_PRECOMP_BIT = 2;  // precomp_disable in config

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] RATE_RESET    = 2'h2;  // 250 Kbps selection
  localparam logic       PRECOMP_RESET = 1'h0;  // Precompensation enabled
  localparam logic       DENSITY_RESET = 1'h1;  // Density pin high
  localparam logic [7:0] READ_IDLE     = 8'h00; // Unmapped read answer
  localparam logic [3:0] PS2_FILL      = 4'hf;  // Bits 6..3 in second mode

  ////////////////////////////////////////////////////////////////////////////
  // Rate selection codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Completion codes of the first result byte
  localparam logic [1:0] END_NORMAL   = 2'h0;
  localparam logic [1:0] END_ABNORMAL = 2'h1;
  localparam logic [1:0] END_INVALID  = 2'h2;
  localparam logic [1:0] END_POLLING  = 2'h3;

  // Step pulses a recalibrate may issue before track zero must show
  localparam int unsigned RECAL_STEPS = 80;

  ////////////////////////////////////////////////////////////////////////////
  // Register modes, one-hot
  typedef enum logic [2:0] {
    MODE_AT    = 3'h1,                          // First, compatible layout
    MODE_PS2   = 3'h2,                          // Second layout
    MODE_MOD30 = 3'h4                           // Third layout
  } fdrs_mode_t;

  // First result status byte
  typedef struct packed {
    logic [1:0] completionCode;                 // Bits 7..6
    logic       positioningFinished;            // Bit 5
    logic       equipmentFault;                 // Bit 4
    logic       zeroBit;                        // Bit 3, always zero
    logic       headNumber;                     // Bit 2
    logic [1:0] driveNumber;                    // Bits 1..0
  } fdrs_status0_t;

  // Events from the command sequencer that shape the status byte
  typedef struct packed {
    logic       commandEnd;                     // Pulse: latch the byte
    logic [1:0] endCode;                        // Completion code to report
    logic       seekDone;                       // Pulse: positioning complete
    logic       recalActive;                    // Level: recalibrate running
    logic       stepPulse;                      // Pulse: one step issued
    logic       relSeekUnderflow;               // Pulse: stepped past zero
    logic       headNow;                        // Current head
    logic [1:0] driveNow;                       // Current drive
  } fdrs_cmd_evt_t;

endpackage : fdrs_pkg

// file: logic/fdrs_status_zero.sv
// Purpose: Builds the first result status byte of a finished command
// Assumes: Sequencer events are one-cycle pulses on mclk
// Notes:   Byte is latched at command end and held until the next one or a reset

`timescale 1ns/100ps

module fdrs_status_zero #(
  parameter int unsigned RECAL_STEPS = fdrs_pkg::RECAL_STEPS
) (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    softReset,
  input  wire fdrs_pkg::fdrs_cmd_evt_t cmdEvt,
  input  wire logic                    trackZeroPin,
  output fdrs_pkg::fdrs_status0_t      statusZero
);

  logic [7:0] stepCount;                        // Steps of this recalibrate
  logic       seekFlag;                         // Positioning finished
  logic       faultFlag;                        // Equipment fault seen
  logic       recalFault;                       // Step limit hit off track 0

  // Limit reached while track zero is still not seen
  assign recalFault = cmdEvt.recalActive &&
                      (stepCount >= 8'(RECAL_STEPS)) && !trackZeroPin;

  ////////////////////////////////////////////////////////////////////////////
  // Step counter; saturates so a stuck drive cannot wrap it back to zero
  always_ff @(posedge mclk) begin
    if (reset || softReset || !cmdEvt.recalActive) begin
      stepCount <= 8'h00;
    end else if (cmdEvt.stepPulse && stepCount != 8'hff) begin
      stepCount <= stepCount + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags; a new event in the latch cycle is kept, not lost
  always_ff @(posedge mclk) begin
    if (reset || softReset) begin
      seekFlag  <= 1'b0;
      faultFlag <= 1'b0;
    end else begin
      seekFlag  <= cmdEvt.seekDone ||
                   (seekFlag && !cmdEvt.commandEnd);
      faultFlag <= recalFault || cmdEvt.relSeekUnderflow ||
                   (faultFlag && !cmdEvt.commandEnd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result byte latch
  always_ff @(posedge mclk) begin
    if (reset || softReset) begin
      statusZero <= '0;
    end else if (cmdEvt.commandEnd) begin
      statusZero.completionCode      <= cmdEvt.endCode;
      statusZero.positioningFinished <= seekFlag || cmdEvt.seekDone;
      statusZero.equipmentFault      <= faultFlag || recalFault ||
                                        cmdEvt.relSeekUnderflow;
      statusZero.zeroBit             <= 1'b0;
      statusZero.headNumber          <= cmdEvt.headNow;
      statusZero.driveNumber         <= cmdEvt.driveNow;
    end
  end

  a_fault_on_limit: assert property (@(posedge mclk) disable iff (reset)
    (recalFault && !softReset) ##1 cmdEvt.commandEnd && !softReset
      |=> statusZero.equipmentFault)
    else $error("Recalibrate limit fault not reported");

  a_code_latched: assert property (@(posedge mclk) disable iff (reset)
    cmdEvt.commandEnd && !softReset
      |=> statusZero.completionCode == $past(cmdEvt.endCode))
    else $error("Completion code not latched");

endmodule : fdrs_status_zero

// file: logic/fdrs_regs.sv
// Purpose: Input status / rate config registers sharing one I/O address,
//          plus the first result status byte of the floppy controller
// Assumes: Host I/O strobes are one-cycle pulses synchronous to mclk
// Notes:   Software reset never touches rate, precomp flag or density pin

`timescale 1ns/100ps

module fdrs_regs #(
  parameter int unsigned RECAL_STEPS = fdrs_pkg::RECAL_STEPS
) (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    softReset,
  input  wire fdrs_pkg::fdrs_mode_t    regMode,
  input  wire logic [9:0]              ioAddr,
  input  wire logic                    ioRead,
  input  wire logic                    ioWrite,
  input  wire logic [7:0]              ioWrData,
  output logic [7:0]                   ioRdData,
  input  wire logic                    diskChangedCable,
  input  wire logic                    forceDiskChange,
  input  wire logic [7:0]              digitalOutputReg,
  input  wire fdrs_pkg::fdrs_cmd_evt_t cmdEvt,
  input  wire logic                    trackZeroPin,
  output logic [1:0]                   rateSelect,
  output logic                         precompDisable,
  output logic                         densitySelectPin,
  output fdrs_pkg::fdrs_status0_t      resultStatusZero
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic       hitShared;                        // Address is the shared port
  logic       cfgWrite;                         // Write into rate config
  logic       dirRead;                          // Read of input status
  logic       diskChanged;                      // Bit 7 value
  logic       lowDensityFlag;                   // Slow rate selected
  logic [7:0] next_rdData;                      // Read data before the flop
  logic [7:0] dirValue;                         // Input status per mode
  logic       xferEnable;                       // Mirror of output reg bit

  assign hitShared = (ioAddr == fdrs_pkg::ADDR_RATE_STATUS);
  // Direction alone steers the shared address to one of two registers
  assign dirRead   = hitShared && ioRead;
  assign cfgWrite  = hitShared && ioWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit sources

  // Cable line is low while a change is pending, hence the inversion
  assign diskChanged = !diskChangedCable || forceDiskChange;

  // Only the two slow rates count as low density
  assign lowDensityFlag = (rateSelect == fdrs_pkg::RATE_250K) ||
                          (rateSelect == fdrs_pkg::RATE_300K);

  assign xferEnable = digitalOutputReg[fdrs_pkg::DOR_XFER_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Input status layout per mode; an unknown mode code falls back to
  // the first layout so a bad strap still yields a harmless byte
  always_comb begin
    dirValue = fdrs_pkg::READ_IDLE;
    unique case (regMode)
      fdrs_pkg::MODE_AT: begin
        dirValue = {diskChanged, 7'h00};
      end
      fdrs_pkg::MODE_PS2: begin
        dirValue = {diskChanged, fdrs_pkg::PS2_FILL,
                    rateSelect[1], rateSelect[0],
                    lowDensityFlag};
      end
      fdrs_pkg::MODE_MOD30: begin
        dirValue = {diskChanged, 3'h0, xferEnable,
                    precompDisable, rateSelect};
        dirValue[fdrs_pkg::M30_XFER_BIT] = xferEnable;
      end
      default: begin
        dirValue = {diskChanged, 7'h00};
      end
    endcase
  end

  // Unmapped or idle cycles answer with zero
  assign next_rdData = dirRead ? dirValue : fdrs_pkg::READ_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Read data register, one cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      ioRdData <= fdrs_pkg::READ_IDLE;
    end else begin
      ioRdData <= next_rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate selection; only a hard reset restores it, soft reset is ignored
  always_ff @(posedge mclk) begin
    if (reset) begin
      rateSelect <= fdrs_pkg::RATE_RESET;
    end else if (cfgWrite) begin
      rateSelect <= ioWrData[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Precompensation-disable flag: stored only in the third mode. It drives
  // nothing in the data path; software may only read it back. Reserved
  // bits are simply dropped, so a host that breaks the zero convention
  // still cannot disturb anything here.
  always_ff @(posedge mclk) begin
    if (reset) begin
      precompDisable <= fdrs_pkg::PRECOMP_RESET;
    end else if (cfgWrite && regMode == fdrs_pkg::MODE_MOD30) begin
      precompDisable <= ioWrData[fdrs_pkg::CFG_PRECOMP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Density pin follows the rate; high on hard reset, blind to soft resets
  always_ff @(posedge mclk) begin
    if (reset) begin
      densitySelectPin <= fdrs_pkg::DENSITY_RESET;
    end else begin
      densitySelectPin <= lowDensityFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // First result status byte, handed to the data register path
  fdrs_status_zero #(
    .RECAL_STEPS (RECAL_STEPS)
  ) u_status_zero (
    .mclk         (mclk),
    .reset        (reset),
    .softReset    (softReset),
    .cmdEvt       (cmdEvt),
    .trackZeroPin (trackZeroPin),
    .statusZero   (resultStatusZero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_write_no_read: assert property (@(posedge mclk) disable iff (reset)
    cfgWrite && !ioRead |=> ioRdData == fdrs_pkg::READ_IDLE)
    else $error("Write to shared address produced read data");

  a_at_low_zero: assert property (@(posedge mclk) disable iff (reset)
    dirRead && regMode == fdrs_pkg::MODE_AT |=> ioRdData[6:0] == 7'h00)
    else $error("First mode low bits not zero");

  a_change_bit: assert property (@(posedge mclk) disable iff (reset)
    dirRead |=> ioRdData[7] ==
      (!$past(diskChangedCable) || $past(forceDiskChange)))
    else $error("Disk change bit wrong");

  a_ps2_density: assert property (@(posedge mclk) disable iff (reset)
    dirRead && regMode == fdrs_pkg::MODE_PS2 && rateSelect[0] != rateSelect[1]
      |=> ioRdData[0])
    else $error("Second mode density bit not high for slow rate");

  a_ps2_layout: assert property (@(posedge mclk) disable iff (reset)
    dirRead && regMode == fdrs_pkg::MODE_PS2
      |=> ioRdData[6:3] == 4'hf && ioRdData[2:1] == $past(rateSelect))
    else $error("Second mode layout wrong");

  a_soft_keeps: assert property (@(posedge mclk) disable iff (reset)
    softReset && !cfgWrite |=> $stable(rateSelect) && $stable(precompDisable))
    else $error("Soft reset disturbed rate or precomp");

  a_m30_mirror: assert property (@(posedge mclk) disable iff (reset)
    dirRead && regMode == fdrs_pkg::MODE_MOD30
      |=> ioRdData[3] == $past(digitalOutputReg[3])
          && ioRdData[6:4] == 3'h0)
    else $error("Third mode transfer mirror wrong");

  // Host strobes are one cycle with an idle cycle between, so a read
  // that follows a write directly is sampled two edges after it
  a_m30_precomp: assert property (@(posedge mclk) disable iff (reset)
    cfgWrite && regMode == fdrs_pkg::MODE_MOD30 ##1 !cfgWrite ##1
      (dirRead && !cfgWrite && regMode == fdrs_pkg::MODE_MOD30)
      |=> ioRdData[2:0] == $past(ioWrData[2:0], 3))
    else $error("Third mode readback wrong");

  a_rate_load: assert property (@(posedge mclk) disable iff (reset)
    cfgWrite |=> rateSelect == $past(ioWrData[1:0]))
    else $error("Rate not loaded by write");

  a_density_slow: assert property (@(posedge mclk) disable iff (reset)
    !cfgWrite [*2] |-> densitySelectPin == lowDensityFlag)
    else $error("Density pin not following rate");

endmodule : fdrs_regs

// file: dv/fdrs_host_model.sv
// Purpose: Host model issuing I/O reads and writes to the registers
// Assumes: Strobes start just after an mclk rising edge, one cycle long
// Notes:   Released lines carry inverted values so stale data never passes

`timescale 1ns/100ps

module fdrs_host_model (
  input  wire logic       mclk,
  input  wire logic       mode30,
  input  wire logic [7:0] ioRdData,
  output logic      [9:0] ioAddr,
  output logic            ioRead,
  output logic            ioWrite,
  output logic      [7:0] ioWrData
);

  // Idle bus at time zero
  initial begin
    ioAddr   = 10'h000;
    ioRead   = 1'h0;
    ioWrite  = 1'h0;
    ioWrData = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // One write; rude keeps reserved bits so the refusal can be probed
  task automatic io_write(input logic [9:0] addr, input logic [7:0] data,
                          input logic rude);
    @(posedge mclk);
    ioAddr   <= addr;
    ioWrite  <= 1'h1;
    // A polite host sends reserved config bits as zero
    ioWrData <= rude ? data : data & (mode30 ? 8'h07 : 8'h03);
    @(posedge mclk);
    ioWrite  <= 1'h0;
    ioAddr   <= ~addr;
    ioWrData <= ~data;
  endtask : io_write

  // One read; answer stands in the cycle after the strobe edge
  task automatic io_read(input logic [9:0] addr, output logic [7:0] data);
    @(posedge mclk);
    ioAddr <= addr;
    ioRead <= 1'h1;
    @(posedge mclk);
    ioRead <= 1'h0;
    ioAddr <= ~addr;
    #1 data = ioRdData;
  endtask : io_read

endmodule : fdrs_host_model

// file: dv/tb_floppy_rate_status_regs.sv
// Purpose: Self-checking bench of the rate config / input status registers
// Assumes: RECAL_STEPS shortened to 4 to keep recalibrate runs brief
// Notes:   Random stimulus from a fixed xorshift seed plus corner cases

`timescale 1ns/100ps

`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
  errors++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end

module tb_floppy_rate_status_regs;
  logic                    mclk = 1'h0;     // 250 MHz clock
  logic                    reset = 1'h1;    // Hard reset
  logic                    softReset = 1'h0;
  fdrs_pkg::fdrs_mode_t    regMode = fdrs_pkg::MODE_AT;
  logic [9:0]              ioAddr;
  logic                    ioRead, ioWrite;
  logic [7:0]              ioWrData, ioRdData, rd, d;
  logic                    diskChangedCable = 1'h1, forceDiskChange = 1'h0;
  logic [7:0]              digitalOutputReg = 8'h00;
  fdrs_pkg::fdrs_cmd_evt_t cmdEvt = '0, idleEvt = '0, ev;
  logic                    trackZeroPin = 1'h1;
  logic [1:0]              rateSelect, rate;
  logic                    precompDisable, densitySelectPin, pc, chg;
  fdrs_pkg::fdrs_status0_t resultStatusZero;
  logic [31:0]             seed = 32'd79087, r;
  int                      errors = 0, samplesChecked = 0;
  fdrs_pkg::fdrs_mode_t    modes [3] = '{fdrs_pkg::MODE_AT,
                             fdrs_pkg::MODE_PS2, fdrs_pkg::MODE_MOD30};

  // Clock: 4 ns period
  always #2 mclk = ~mclk;

  fdrs_regs #(.RECAL_STEPS(4)) dut_u (.mclk(mclk), .reset(reset),
    .softReset(softReset), .regMode(regMode), .ioAddr(ioAddr),
    .ioRead(ioRead), .ioWrite(ioWrite), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .diskChangedCable(diskChangedCable),
    .forceDiskChange(forceDiskChange), .digitalOutputReg(digitalOutputReg),
    .cmdEvt(cmdEvt), .trackZeroPin(trackZeroPin), .rateSelect(rateSelect),
    .precompDisable(precompDisable), .densitySelectPin(densitySelectPin),
    .resultStatusZero(resultStatusZero));

  fdrs_host_model host_u (.mclk(mclk),
    .mode30(regMode == fdrs_pkg::MODE_MOD30), .ioRdData(ioRdData),
    .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
    .ioWrData(ioWrData));

  ////////////////////////////////////////////////////////////////////////////
  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected input status byte for a mode and register state
  function automatic logic [7:0] exp_dir(fdrs_pkg::fdrs_mode_t m,
      logic [1:0] rt, logic p, logic c, logic dma);
    case (m)
      fdrs_pkg::MODE_PS2:   return {c, 4'hf, rt, rt[1] ^ rt[0]};
      fdrs_pkg::MODE_MOD30: return {c, 3'h0, dma, p, rt};
      default:              return {c, 7'h00};
    endcase
  endfunction : exp_dir

  // One sequencer event cycle, then back to the idle pattern
  task automatic pulse(input fdrs_pkg::fdrs_cmd_evt_t e);
    @(posedge mclk);
    cmdEvt <= e;
    @(posedge mclk);
    cmdEvt <= idleEvt;
  endtask : pulse

  // End a command and check the latched first result byte
  task automatic end_cmd(input logic [1:0] code, input logic [7:0] exp);
    ev = idleEvt;
    ev.commandEnd = 1'h1;
    ev.endCode = code;
    pulse(ev);
    @(posedge mclk);
    #1 `CHK(resultStatusZero, exp)
  endtask : end_cmd

  // Verdict; the only place the run ends
  task automatic close_out();
    $display("errors %0d samplesChecked %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    #1 `CHK(rateSelect, fdrs_pkg::RATE_250K)
    `CHK({precompDisable, densitySelectPin}, 2'h1)
    regMode <= fdrs_pkg::MODE_MOD30;
    host_u.io_read(10'h3f7, rd);
    `CHK(rd[6:0], 7'h02)
    rate = fdrs_pkg::RATE_250K;
    pc = 1'h0;
    // Random writes and reads over every mode and rate
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      @(posedge mclk);
      regMode <= modes[i % 3];
      diskChangedCable <= r[8];
      forceDiskChange <= r[9] & r[10];
      digitalOutputReg <= r[23:16];
      d = {r[7:2], i[3:2]};
      host_u.io_write(10'h3f7, d, r[11]);
      rate = d[1:0];
      if (modes[i % 3] == fdrs_pkg::MODE_MOD30) pc = d[2];
      chg = ~r[8] | (r[9] & r[10]);
      // Read straight after the write to reach the fresh readback path
      host_u.io_read(10'h3f7, rd);
      `CHK(rd, exp_dir(modes[i % 3], rate, pc, chg, r[19]))
      host_u.io_write(10'h3f6, ~d, 1'h1);
      host_u.io_read(10'h3f7, rd);
      `CHK(rd, exp_dir(modes[i % 3], rate, pc, chg, r[19]))
      `CHK({rateSelect, precompDisable}, {rate, pc})
      `CHK(densitySelectPin, rate[1] ^ rate[0])
      host_u.io_read(10'h3f5, rd);
      `CHK(rd, 8'h00)
    end
    // Software reset keeps rate, precomp flag and density pin
    @(posedge mclk);
    softReset <= 1'h1;
    @(posedge mclk);
    softReset <= 1'h0;
    repeat (2) @(posedge mclk);
    #1 `CHK({rateSelect, precompDisable}, {rate, pc})
    `CHK(densitySelectPin, rate[1] ^ rate[0])
    // Completion codes with seek flag, head and drive
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      ev = '0;
      ev.seekDone = r[0];
      pulse(ev);
      idleEvt.headNow = r[1];
      idleEvt.driveNow = r[3:2];
      end_cmd(i[1:0], {i[1:0], r[0], 2'h0, r[1], r[3:2]});
      idleEvt = '0;
    end
    // Recalibrate one step short of the limit, then at it
    @(posedge mclk);
    trackZeroPin <= 1'h0;
    for (int n = 3; n < 5; n++) begin
      idleEvt.recalActive = 1'h1;
      ev = idleEvt;
      ev.stepPulse = 1'h1;
      repeat (n) pulse(ev);
      end_cmd(fdrs_pkg::END_ABNORMAL, (n == 4) ? 8'h50 : 8'h40);
      idleEvt = '0;
      pulse(idleEvt);
    end
    // Relative seek stepping past track zero; a soft reset first clears
    // the fault left over from the recalibrate so only underflow sets it
    @(posedge mclk);
    softReset <= 1'h1;
    @(posedge mclk);
    softReset <= 1'h0;
    ev = '0;
    ev.relSeekUnderflow = 1'h1;
    pulse(ev);
    end_cmd(fdrs_pkg::END_NORMAL, 8'h10);
    // Hard reset in mid-run restores rate and density pin
    host_u.io_write(10'h3f7, 8'h03, 1'h0);
    repeat (2) @(posedge mclk);
    #1 `CHK(densitySelectPin, 1'h0)
    @(posedge mclk);
    reset <= 1'h1;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    #1 `CHK({rateSelect, densitySelectPin}, 3'h5)
    `CHK(resultStatusZero, 8'h00)
    close_out();
  end

endmodule : tb_floppy_rate_status_regs
